/* File: clock_gen_pkg.sv */
// Package for the clock generator mode logic.
// Assumes a single 10 MHz system clock and a synchronous active-high reset.
package clock_gen_pkg;

   // Wishbone register word addresses (byte address, 32-bit aligned).
   localparam logic [3:0] ADDR_CTRL1 = 4'h0;
   localparam logic [3:0] ADDR_CTRL2 = 4'h4;
   localparam logic [3:0] ADDR_TRIM = 4'h8;
   localparam logic [3:0] ADDR_STATUS = 4'hC;

   // Control 1 field positions.
   localparam int CTRL1_SRC_LSB = 6;
   localparam int CTRL1_REFERENCE_DIVIDER_LSB = 3;
   localparam int CTRL1_REFSEL_BIT = 2;
   localparam int CTRL1_IROE_BIT = 1;
   localparam int CTRL1_IRSTOP_BIT = 0;

   // Control 2 field positions.
   localparam int CTRL2_BUS_DIVIDER_LSB = 6;
   localparam int CTRL2_LP_BIT = 3;
   localparam int CTRL2_EROE_BIT = 1;
   localparam int CTRL2_ERSTOP_BIT = 0;

   // Status field positions.
   localparam int STAT_MODE_LSB = 2;
   localparam int STAT_FINE_BIT = 0;

   // Reset values, and the power-up value of the trim field.
   localparam logic [1:0] SRC_RESET = 2'h0;
   localparam logic [2:0] REFERENCE_DIVIDER_RESET = 3'h0;
   localparam logic REFSEL_RESET = 1'b1;
   localparam logic [1:0] BUS_DIVIDER_RESET = 2'h1;
   localparam logic [7:0] TRIM_POWERUP = 8'h80;

   // Source select codes.
   localparam logic [1:0] SRC_LOOP = 2'h0;
   localparam logic [1:0] SRC_INTREF = 2'h1;
   localparam logic [1:0] SRC_EXTREF = 2'h2;

   // Loop lock ratio and fixed-frequency margin.
   localparam int LOCK_RATIO = 512;
   localparam logic [2:0] FFV_MARGIN = 3'h2;
   localparam logic [2:0] REFERENCE_DIVIDER_DIV128 = 3'h6;

   // Full cycles of a new clock counted before a source switch.
   localparam logic [2:0] SETTLE_CYCLES = 3'h4;

   // System clock.
   localparam int CLK_HZ = 10000000;

   typedef enum logic [1:0] {
      SW_IDLE,
      SW_WAIT,
      SW_DONE
   } switch_state_t;

endpackage

/* File: clock_source_model.sv */
// Model of the reference oscillators and loop clock feeding the generator.
// Assumes it is stepped by the system clock; half periods are in cycles.
`timescale 1ns/1ps
module clock_source_model #(
   parameter int INT_HALF = 4,
   parameter int EXT_HALF = 3
) (
   // System.
   input wire logic clock,
   // Oscillator running, commanded by the bench.
   input wire logic extOn,
   // Source clocks.
   output logic intRefClk = 1'b0,
   output logic extRefClk = 1'b0,
   output logic loopClk = 1'b0,
   output logic extRefAvailable = 1'b1
);
   int intCnt = 0;
   int extCnt = 0;
   // A stopped oscillator gives no edges and reports itself unusable.
   always @(posedge clock) begin
      intCnt <= (intCnt == INT_HALF - 1) ? 0 : intCnt + 1;
      extCnt <= (extCnt == EXT_HALF - 1) ? 0 : extCnt + 1;
      intRefClk <= (intCnt == INT_HALF - 1) ? !intRefClk : intRefClk;
      extRefClk <= !extOn ? 1'b0 : ((extCnt == EXT_HALF - 1) ? !extRefClk : extRefClk);
      extRefAvailable <= extOn;
      loopClk <= !loopClk;
   end
endmodule

/* File: fll_clock_source_mode_control.sv */
// Clock generator mode logic: source selection, loop control, dividers, stop gating.
// Assumes reference and loop clocks arrive as asynchronous levels sampled on clock,
// and a classic Wishbone master on the same clock.
//
// Our own choices: the register addresses and the Wishbone register port.
`timescale 1ns/1ps

// Overview of operation
// - Reset selects loop-engaged internal: source 00, reference select 1.
// - Running loop targets 512 times the divided reference frequency.
// - Source 00 with reference 0 runs loop from external reference.
// - Source 01, reference 1, power-down 0: output internal ref, loop runs.
// - Source 01, reference 1, power-down 1: output internal ref, loop off.
// - Source 10, reference 0, power-down 0: output external ref, loop runs.
// - Source 10, reference 0, power-down 1: output external ref, loop off.
// - Stop freezes clock outputs except internal or external ref if enabled and stop-kept.
// - External ref output runs in stop only if enabled and stop-kept.
// - After reference select changes, relock after a few divided-reference cycles.
// - Source switch waits few new-clock cycles; unavailable clock keeps old one.
// - Bus divider writes take effect immediately.
// - Internal ref output enable presents internal reference as separate clock.
// - Larger period adjust slows internal reference; affects internally referenced modes.
// - Coarse and fine period adjust survive any reset.
// - Reference select 1 keeps external reference away from the loop.
// - Fixed-frequency clock is the divided loop reference.
// - Fixed-frequency-valid is high in both loop-engaged modes.
// - Bypass modes: valid when reference divider code >= bus divider code + 2.
// - Bus divider divides by 1, 2, 4, 8; code 01 at reset.
// - Reference divider 1..32 for codes 000..101, 128 for 110; 000 at reset.
// - Mode status reports actual source, lagging the select write.
// - In stop the loop is disabled and no main clock is output.
module fll_clock_source_mode_control
   import clock_gen_pkg::*;
#(
   parameter int SETTLE_DIVREF = 4
) (
   // System.
   input wire logic clock,
   input wire logic rst,
   // Wishbone slave.
   input wire logic cyc_i,
   input wire logic stb_i,
   input wire logic we_i,
   input wire logic [3:0] adr_i,
   input wire logic [3:0] sel_i,
   input wire logic [31:0] dat_i,
   output logic [31:0] dat_o,
   output logic ack_o,
   // Clock sources, asynchronous to clock.
   input wire logic intRefClk,
   input wire logic extRefClk,
   input wire logic loopClk,
   input wire logic extRefAvailable,
   // Chip state.
   input wire logic stopMode,
   // Generated clocks and indicators.
   output logic main_clock_out,
   output logic internal_ref_clock_out,
   output logic external_ref_clock_out,
   output logic fixed_freq_clock,
   output logic fixed_freq_valid,
   output logic loopEnable,
   output logic loopRefSelInternal,
   output logic loopRelock,
   output logic [7:0] periodAdjust,
   output logic fine_period_adjust,
   output logic [9:0] lockMultiplier
);
   import clock_gen_pkg::*;

   ////////////////////////////////////////////////////////////////////////////
   // Registers.
   logic [1:0] clockSourceSelect_q;
   logic [2:0] referenceDivider_q;
   logic referenceSelect_q;
   logic intRefOutEnable_q;
   logic intRefStopKeep_q;
   logic [1:0] busDivider_q;
   logic loopPowerDown_q;
   logic extRefOutEnable_q;
   logic extRefStopKeep_q;
   logic [7:0] trim_q = TRIM_POWERUP;
   logic fineTrim_q = 1'b0;
   logic [1:0] activeSource_q;
   logic ackPend_q;

   logic access;
   logic wrCtrl1;
   logic wrCtrl2;
   logic wrTrim;
   logic wrStatus;
   assign access = cyc_i & stb_i & ~ackPend_q;
   assign wrCtrl1 = access & we_i & sel_i[0] & (adr_i == ADDR_CTRL1);
   assign wrCtrl2 = access & we_i & sel_i[0] & (adr_i == ADDR_CTRL2);
   assign wrTrim = access & we_i & sel_i[0] & (adr_i == ADDR_TRIM);
   assign wrStatus = access & we_i & sel_i[0] & (adr_i == ADDR_STATUS);

   // One-cycle ack for every access, mapped or not.
   always_ff @(posedge clock) begin
      if (rst) begin
         ackPend_q <= 1'b0;
      end else begin
         ackPend_q <= access;
      end
   end
   assign ack_o = ackPend_q;

   always_ff @(posedge clock) begin
      if (rst) begin
         clockSourceSelect_q <= SRC_RESET;
         referenceDivider_q <= REFERENCE_DIVIDER_RESET;
         referenceSelect_q <= REFSEL_RESET;
         intRefOutEnable_q <= 1'b0;
         intRefStopKeep_q <= 1'b0;
      end else if (wrCtrl1) begin
         clockSourceSelect_q <= dat_i[CTRL1_SRC_LSB +: 2];
         referenceDivider_q <= dat_i[CTRL1_REFERENCE_DIVIDER_LSB +: 3];
         referenceSelect_q <= dat_i[CTRL1_REFSEL_BIT];
         intRefOutEnable_q <= dat_i[CTRL1_IROE_BIT];
         intRefStopKeep_q <= dat_i[CTRL1_IRSTOP_BIT];
      end
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         busDivider_q <= BUS_DIVIDER_RESET;
         loopPowerDown_q <= 1'b0;
         extRefOutEnable_q <= 1'b0;
         extRefStopKeep_q <= 1'b0;
      end else if (wrCtrl2) begin
         busDivider_q <= dat_i[CTRL2_BUS_DIVIDER_LSB +: 2];
         loopPowerDown_q <= dat_i[CTRL2_LP_BIT];
         extRefOutEnable_q <= dat_i[CTRL2_EROE_BIT];
         extRefStopKeep_q <= dat_i[CTRL2_ERSTOP_BIT];
      end
   end

   // Trim fields ignore reset entirely.
   always_ff @(posedge clock) begin
      if (wrTrim) begin
         trim_q <= dat_i[7:0];
      end
      if (wrStatus) begin
         fineTrim_q <= dat_i[STAT_FINE_BIT];
      end
   end
   assign periodAdjust = trim_q;
   assign fine_period_adjust = fineTrim_q;

   always_ff @(posedge clock) begin
      if (rst) begin
         dat_o <= 32'h0;
      end else if (access && !we_i) begin
         case (adr_i)
            ADDR_CTRL1: dat_o <= {24'h0, clockSourceSelect_q, referenceDivider_q,
               referenceSelect_q, intRefOutEnable_q, intRefStopKeep_q};
            ADDR_CTRL2: dat_o <= {24'h0, busDivider_q, 2'h0, loopPowerDown_q, 1'b0,
               extRefOutEnable_q, extRefStopKeep_q};
            ADDR_TRIM: dat_o <= {24'h0, trim_q};
            ADDR_STATUS: dat_o <= {28'h0, activeSource_q, 1'b0, fineTrim_q};
            default: dat_o <= 32'h0;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Input synchronisers.
   logic [2:0] syncA_q;
   logic [2:0] syncB_q;
   logic syncAvA_q;
   logic syncAvB_q;
   always_ff @(posedge clock) begin
      if (rst) begin
         syncA_q <= 3'h0;
         syncB_q <= 3'h0;
         syncAvA_q <= 1'b0;
         syncAvB_q <= 1'b0;
      end else begin
         syncA_q <= {loopClk, extRefClk, intRefClk};
         syncB_q <= syncA_q;
         syncAvA_q <= extRefAvailable;
         syncAvB_q <= syncAvA_q;
      end
   end
   logic intRefS;
   logic extRefS;
   logic loopS;
   assign intRefS = syncB_q[0];
   assign extRefS = syncB_q[1];
   assign loopS = syncB_q[2];

   ////////////////////////////////////////////////////////////////////////////
   // Loop reference and reference divider.
   logic loopRef;
   logic [6:0] refCnt_q;
   logic refPrev_q;
   logic refRise;
   assign loopRef = referenceSelect_q ? intRefS : extRefS;
   assign refRise = loopRef & ~refPrev_q;
   always_ff @(posedge clock) begin
      if (rst) begin
         refPrev_q <= 1'b0;
         refCnt_q <= 7'h0;
      end else begin
         refPrev_q <= loopRef;
         if (refRise) begin
            refCnt_q <= refCnt_q + 7'h1;
         end
      end
   end

   // Divided reference, one tap per code.
   logic divRef;
   always_comb begin
      if (referenceDivider_q == 3'h0) begin
         divRef = loopRef;
      end else if (referenceDivider_q >= REFERENCE_DIVIDER_DIV128) begin
         divRef = refCnt_q[6];
      end else begin
         divRef = refCnt_q[referenceDivider_q - 3'h1];
      end
   end

   logic divRefPrev_q;
   always_ff @(posedge clock) begin
      if (rst) begin
         divRefPrev_q <= 1'b0;
         fixed_freq_clock <= 1'b0;
      end else begin
         divRefPrev_q <= divRef;
         if (!stopMode) begin
            fixed_freq_clock <= divRef;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Loop enable and relock.
   logic loopMode;
   assign loopMode = (clockSourceSelect_q == SRC_LOOP);
   assign loopEnable = ~stopMode & (loopMode | ~loopPowerDown_q);
   assign loopRefSelInternal = referenceSelect_q;
   assign lockMultiplier = 10'(LOCK_RATIO);

   logic refSelPrev_q;
   logic [3:0] relockCnt_q;
   always_ff @(posedge clock) begin
      if (rst) begin
         refSelPrev_q <= REFSEL_RESET;
         relockCnt_q <= 4'h0;
         loopRelock <= 1'b0;
      end else begin
         refSelPrev_q <= referenceSelect_q;
         loopRelock <= 1'b0;
         if (referenceSelect_q != refSelPrev_q) begin
            relockCnt_q <= 4'(SETTLE_DIVREF);
         end else if (relockCnt_q != 4'h0 && divRef && !divRefPrev_q) begin
            relockCnt_q <= relockCnt_q - 4'h1;
            loopRelock <= (relockCnt_q == 4'h1);
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Glitch-free source switch.
   logic newClk;
   always_comb begin
      case (clockSourceSelect_q)
         SRC_INTREF: newClk = intRefS;
         SRC_EXTREF: newClk = extRefS;
         default: newClk = loopS;
      endcase
   end
   logic newAvail;
   logic selClk;
   assign newAvail = (clockSourceSelect_q != SRC_EXTREF) | syncAvB_q;

   switch_state_t swState_q;
   logic [2:0] newCnt_q;
   logic newPrev_q;
   always_ff @(posedge clock) begin
      if (rst) begin
         swState_q <= SW_IDLE;
         activeSource_q <= SRC_RESET;
         newCnt_q <= 3'h0;
         newPrev_q <= 1'b0;
      end else begin
         newPrev_q <= newClk;
         case (swState_q)
            SW_IDLE: begin
               if (clockSourceSelect_q != activeSource_q && newAvail) begin
                  swState_q <= SW_WAIT;
                  newCnt_q <= 3'h0;
               end
            end
            SW_WAIT: begin
               if (clockSourceSelect_q == activeSource_q || !newAvail) begin
                  swState_q <= SW_IDLE;
               end else if (newClk && !newPrev_q) begin
                  newCnt_q <= newCnt_q + 3'h1;
                  if (newCnt_q + 3'h1 >= SETTLE_CYCLES) begin
                     swState_q <= SW_DONE;
                  end
               end
            end
            SW_DONE: begin
               // Change over only while both old and new clocks are low.
               if (!selClk && !newClk) begin
                  activeSource_q <= clockSourceSelect_q;
                  swState_q <= SW_IDLE;
               end
            end
            default: swState_q <= SW_IDLE;
         endcase
      end
   end

   always_comb begin
      case (activeSource_q)
         SRC_INTREF: selClk = intRefS;
         SRC_EXTREF: selClk = extRefS;
         default: selClk = loopS;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////
   // Bus divider, applied at once.
   logic [2:0] busCnt_q;
   logic selPrev_q;
   always_ff @(posedge clock) begin
      if (rst) begin
         busCnt_q <= 3'h0;
         selPrev_q <= 1'b0;
      end else begin
         selPrev_q <= selClk;
         if (selClk && !selPrev_q) begin
            busCnt_q <= busCnt_q + 3'h1;
         end
      end
   end
   logic busClk;
   always_comb begin
      case (busDivider_q)
         2'h0: busClk = selClk;
         2'h1: busClk = busCnt_q[0];
         2'h2: busClk = busCnt_q[1];
         default: busClk = busCnt_q[2];
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////
   // Clock outputs with stop gating.
   always_ff @(posedge clock) begin
      if (rst) begin
         main_clock_out <= 1'b0;
         internal_ref_clock_out <= 1'b0;
         external_ref_clock_out <= 1'b0;
      end else begin
         if (!stopMode) begin
            main_clock_out <= busClk;
         end
         if (intRefOutEnable_q && (!stopMode || intRefStopKeep_q)) begin
            internal_ref_clock_out <= intRefS;
         end else if (!intRefOutEnable_q) begin
            internal_ref_clock_out <= 1'b0;
         end
         if (extRefOutEnable_q && (!stopMode || extRefStopKeep_q)) begin
            external_ref_clock_out <= extRefS;
         end else if (!extRefOutEnable_q) begin
            external_ref_clock_out <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Fixed-frequency-valid.
   always_ff @(posedge clock) begin
      if (rst) begin
         fixed_freq_valid <= 1'b1;
      end else if (activeSource_q == SRC_LOOP) begin
         fixed_freq_valid <= 1'b1;
      end else begin
         fixed_freq_valid <= (referenceDivider_q >= {1'b0, busDivider_q} + FFV_MARGIN);
      end
   end

endmodule

/* File: fll_mode_sva.sv */
// Checker for the clock generator mode logic, bound to its top module.
// Assumes one-byte register writes in bits 7:0 of a classic bus.
`timescale 1ns/1ps
module fll_mode_sva (
   // System.
   input wire logic clock,
   input wire logic rst,
   // Bus.
   input wire logic cyc_i,
   input wire logic stb_i,
   input wire logic we_i,
   input wire logic [3:0] adr_i,
   input wire logic [3:0] sel_i,
   input wire logic [31:0] dat_i,
   input wire logic ack_o,
   // Chip state and outputs.
   input wire logic stopMode,
   input wire logic main_clock_out,
   input wire logic internal_ref_clock_out,
   input wire logic external_ref_clock_out,
   input wire logic fixed_freq_clock,
   input wire logic loopEnable,
   input wire logic loopRefSelInternal,
   input wire logic loopRelock,
   input wire logic [9:0] lockMultiplier
);
   logic [7:0] ctl1_q;
   logic [7:0] ctl2_q;
   logic wrTake;
   logic irGate;
   logic erGate;
   assign wrTake = cyc_i && stb_i && we_i && !ack_o && sel_i[0];
   assign irGate = !ctl1_q[1] || (stopMode && !ctl1_q[0]);
   assign erGate = !ctl2_q[1] || (stopMode && !ctl2_q[0]);
   ////////////////////////////////////////////////////////////////////////////
   // Mirrors of the control bytes, updated on the edge that takes a write.
   always_ff @(posedge clock) begin
      if (rst) begin
         ctl1_q <= 8'h04;
      end else if (wrTake && adr_i == 4'h0) begin
         ctl1_q <= dat_i[7:0];
      end
   end
   always_ff @(posedge clock) begin
      if (rst) begin
         ctl2_q <= 8'h40;
      end else if (wrTake && adr_i == 4'h4) begin
         ctl2_q <= dat_i[7:0];
      end
   end
   ////////////////////////////////////////////////////////////////////////////
   default clocking @(posedge clock); endclocking
   default disable iff (rst);
   sequence reqTaken;
      cyc_i && stb_i && !ack_o;
   endsequence
   sequence irQuiet;
      irGate [*2];
   endsequence
   sequence erQuiet;
      erGate [*2];
   endsequence
   AST_ACK_NEXT: assert property (reqTaken |=> ack_o)
      else $error("bus request not answered in the next cycle");
   AST_ACK_PULSE: assert property (ack_o |=> !ack_o)
      else $error("acknowledge held longer than one cycle");
   AST_LOCK_RATIO: assert property (lockMultiplier == 10'h200)
      else $error("lock multiplier wrong");
   AST_STOP_MAIN: assert property (stopMode |=> $stable(main_clock_out))
      else $error("main clock moved in stop");
   AST_STOP_FIXED: assert property (stopMode |=> $stable(fixed_freq_clock))
      else $error("fixed clock moved in stop");
   AST_STOP_LOOP: assert property (stopMode |-> !loopEnable)
      else $error("loop enabled in stop");
   AST_LOOP_RUN: assert property (!stopMode && !ctl2_q[3] |-> loopEnable)
      else $error("loop off while power-down is clear");
   AST_REF_SEL: assert property (loopRefSelInternal == ctl1_q[2])
      else $error("loop reference select differs from control");
   AST_IR_GATE: assert property (irQuiet |=> $stable(internal_ref_clock_out))
      else $error("internal reference output moved while gated");
   AST_ER_GATE: assert property (erQuiet |=> $stable(external_ref_clock_out))
      else $error("external reference output moved while gated");
   AST_RELOCK_PULSE: assert property (loopRelock |=> !loopRelock)
      else $error("relock longer than one cycle");
endmodule

bind fll_clock_source_mode_control fll_mode_sva i_fll_mode_sva (.clock(clock), .rst(rst),
   .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i),
   .ack_o(ack_o), .stopMode(stopMode), .main_clock_out(main_clock_out),
   .internal_ref_clock_out(internal_ref_clock_out),
   .external_ref_clock_out(external_ref_clock_out), .fixed_freq_clock(fixed_freq_clock),
   .loopEnable(loopEnable), .loopRefSelInternal(loopRefSelInternal),
   .loopRelock(loopRelock), .lockMultiplier(lockMultiplier));

/* File: tb_top.sv */
// Self-checking bench for the clock generator mode logic.
// Assumes a one-cycle bus answer and sources modelled in system-clock cycles.
`timescale 1ns/1ps
module tb_top;
   import clock_gen_pkg::*;
   logic clock = 1'b0;
   logic rst = 1'b1;
   logic cyc = 1'b0;
   logic stb = 1'b0;
   logic we = 1'b0;
   logic stopMode = 1'b0;
   logic extOn = 1'b1;
   logic [3:0] adr = 4'h0;
   logic [3:0] sel = 4'hF;
   logic [31:0] wdat = 32'h0;
   logic [31:0] datO;
   logic [7:0] trim;
   logic [9:0] mult;
   logic ackO, intRef, extRef, loopClk, extAvail, mainClk, irClk, erClk, ffClk;
   logic ffValid, loopEn, refInt, relock, fine;
   logic [7:0] q;
   logic [1:0] s;
   int fails = 0;
   int total_checks = 0;
   int nMain, nFf, nIr, nEr, nRel, e;
   logic [11:0] mSrc = 12'h285;
   logic [5:0] mRef = 6'b000111;
   logic [5:0] mLp = 6'b110110;
   clock_source_model i_clock_source_model (.clock(clock), .extOn(extOn), .intRefClk(intRef),
      .extRefClk(extRef), .loopClk(loopClk), .extRefAvailable(extAvail));
   fll_clock_source_mode_control #(.SETTLE_DIVREF(2)) i_fll_clock_source_mode_control (
      .clock(clock), .rst(rst), .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr),
      .sel_i(sel), .dat_i(wdat), .dat_o(datO), .ack_o(ackO), .intRefClk(intRef),
      .extRefClk(extRef), .loopClk(loopClk), .extRefAvailable(extAvail),
      .stopMode(stopMode), .main_clock_out(mainClk), .internal_ref_clock_out(irClk),
      .external_ref_clock_out(erClk), .fixed_freq_clock(ffClk), .fixed_freq_valid(ffValid),
      .loopEnable(loopEn), .loopRefSelInternal(refInt), .loopRelock(relock),
      .periodAdjust(trim), .fine_period_adjust(fine), .lockMultiplier(mult));
   initial begin
      forever #50 clock = ~clock;
   end
   ////////////////////////////////////////////////////////////////////////////
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         fails++;
         $display("[FAIL] %s expected %0h seen %0h", what, exp, seen);
      end
   endtask
   // One bus cycle, entered just after a rising edge; read data lands in q.
   task automatic xfer(input logic [3:0] a, input logic w, input logic [7:0] d);
      int n;
      n = 0;
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= {24'h0, d};
      do begin
         @(posedge clock);
         n++;
      end while (ackO !== 1'b1 && n < 20);
      if (n >= 20) fails++;
      q = datO[7:0];
      cyc <= 1'b0;
      stb <= 1'b0;
      we <= 1'b0;
      @(posedge clock);
   endtask
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      xfer(a, 1'b1, d);
   endtask
   task automatic waitSrc(input logic [1:0] src);
      int n;
      n = 0;
      do begin
         xfer(ADDR_STATUS, 1'b0, 8'h00);
         n++;
      end while (q[3:2] !== src && n < 60);
      check("status source", 32'(q[3:2]), 32'(src));
   endtask
   // Counts rising edges of the generated clocks and relock pulses.
   task automatic count(input int cycles);
      logic pm, pf, pi, pe;
      nMain = 0;
      nFf = 0;
      nIr = 0;
      nEr = 0;
      nRel = 0;
      pm = mainClk;
      pf = ffClk;
      pi = irClk;
      pe = erClk;
      repeat (cycles) begin
         @(posedge clock);
         if (mainClk === 1'b1 && !pm) nMain++;
         if (ffClk === 1'b1 && !pf) nFf++;
         if (irClk === 1'b1 && !pi) nIr++;
         if (erClk === 1'b1 && !pe) nEr++;
         if (relock === 1'b1) nRel++;
         pm = mainClk;
         pf = ffClk;
         pi = irClk;
         pe = erClk;
      end
   endtask
   task automatic conclude;
      $display("checks %0d mismatches %0d", total_checks, fails);
      if (fails == 0 && total_checks > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (40000) @(posedge clock);
      fails++;
      conclude();
   end
   initial begin
      repeat (6) @(posedge clock);
      rst <= 1'b0;
      xfer(ADDR_CTRL1, 1'b0, 8'h00);
      check("ctrl1 reset", 32'(q), 32'h04);
      xfer(ADDR_CTRL2, 1'b0, 8'h00);
      check("ctrl2 reset", 32'(q), 32'h40);
      check("ff valid reset", 32'(ffValid), 32'h1);
      check("lock ratio", 32'(mult), 32'd512);
      wr(ADDR_TRIM, 8'h5A);
      wr(ADDR_STATUS, 8'h01);
      sel <= 4'h0;
      wr(ADDR_CTRL1, 8'hFF);
      sel <= 4'hF;
      xfer(ADDR_CTRL1, 1'b0, 8'h00);
      check("masked write", 32'(q), 32'h04);
      wr(4'h2, 8'hFF);
      xfer(4'h2, 1'b0, 8'h00);
      check("unmapped read", 32'(q), 32'h0);
      rst <= 1'b1;
      repeat (2) @(posedge clock);
      rst <= 1'b0;
      @(posedge clock);
      xfer(ADDR_TRIM, 1'b0, 8'h00);
      check("trim kept", 32'(q), 32'h5A);
      check("trim port", 32'(trim), 32'h5A);
      check("fine kept", 32'(fine), 32'h1);
      $display("test registers done");
      for (int i = 0; i < 6; i++) begin
         s = mSrc[2*i +: 2];
         wr(ADDR_CTRL2, {2'h1, 2'h0, mLp[i], 3'h0});
         wr(ADDR_CTRL1, {s, 3'h3, mRef[i], 2'h0});
         waitSrc(s);
         check("loop enable", 32'(loopEn), 32'(s == 2'h0 || !mLp[i]));
         check("loop ref", 32'(refInt), 32'(mRef[i]));
         check("ff valid", 32'(ffValid), 32'h1);
      end
      count(300);
      wr(ADDR_CTRL1, 8'h04);
      count(200);
      check("relock pulses", 32'(nRel), 32'h1);
      extOn <= 1'b0;
      wr(ADDR_CTRL1, 8'h80);
      count(200);
      xfer(ADDR_STATUS, 1'b0, 8'h00);
      check("source kept", 32'(q[3:2]), 32'h0);
      extOn <= 1'b1;
      waitSrc(2'h2);
      $display("test modes done");
      wr(ADDR_CTRL1, 8'h44);
      waitSrc(2'h1);
      for (int b = 0; b < 4; b++) begin
         wr(ADDR_CTRL2, {b[1:0], 6'h00});
         count(256);
         e = 32 >> b;
         check("main rises", 32'(nMain >= e - 1 && nMain <= e + 1), 32'h1);
         for (int d = 1; d < 3; d++) begin
            wr(ADDR_CTRL1, {2'h1, 3'(b + d), 3'h4});
            @(posedge clock);
            check("bypass valid", 32'(ffValid), 32'(d == 2));
         end
      end
      for (int k = 0; k < 3; k++) begin
         wr(ADDR_CTRL1, {2'h1, 3'(3 * k), 3'h4});
         count(2048);
         e = 256 / ((k == 2) ? 128 : (1 << (3 * k)));
         check("fixed rises", 32'(nFf >= e - 1 && nFf <= e + 1), 32'h1);
      end
      $display("test dividers done");
      wr(ADDR_CTRL2, 8'h42);
      wr(ADDR_CTRL1, 8'h47);
      stopMode <= 1'b1;
      @(posedge clock);
      count(256);
      check("stop main", 32'(nMain), 32'h0);
      check("stop fixed", 32'(nFf + nEr), 32'h0);
      check("stop internal", 32'(nIr > 20), 32'h1);
      check("stop loop", 32'(loopEn), 32'h0);
      stopMode <= 1'b0;
      count(256);
      check("ref outputs", 32'(nIr > 20 && nEr > 20 && nMain > 0), 32'h1);
      $display("test stop done");
      conclude();
   end
endmodule
